//--- coc_comparator_ctrl.sv
`timescale 1ns/1ps
`default_nettype none

module coc_comparator_ctrl (
    // clock, bus reset and power-on reset
    input wire logic aclk,
    input wire logic aresetn,
    input wire logic por_n,
    // axi4-lite write address
    input wire logic awvalid,
    output logic awready,
    input wire logic [31:0] awaddr,
    input wire logic [2:0] awprot,
    // axi4-lite write data
    input wire logic wvalid,
    output logic wready,
    input wire logic [31:0] wdata,
    input wire logic [3:0] wstrb,
    // axi4-lite write response
    output logic bvalid,
    input wire logic bready,
    output logic [1:0] bresp,
    // axi4-lite read address
    input wire logic arvalid,
    output logic arready,
    input wire logic [31:0] araddr,
    input wire logic [2:0] arprot,
    // axi4-lite read data
    output logic rvalid,
    input wire logic rready,
    output logic [31:0] rdata,
    output logic [1:0] rresp,
    // analog comparator
    input wire logic comp_decision,
    output logic comp_power_en,
    output logic [1:0] comp_response_mode,
    output logic [1:0] comp_hyst_pos,
    output logic [1:0] comp_hyst_neg,
    output logic [3:0] noninverting_input,
    output logic [3:0] inverting_input,
    // pin drivers
    output logic comparator_sync_out,
    output logic comparator_raw_out,
    output logic sync_pin_out,
    output logic sync_pin_oe_n,
    output logic raw_pin_out,
    output logic raw_pin_oe_n,
    // interrupt and reset request
    output logic irq,
    output logic comp_reset_req
);
    // ************************************************************
    // state
    // ************************************************************
    typedef struct packed {
        logic aw_got;
        logic [coc_pkg::ADDR_W-1:0] aw_addr;
        logic w_got;
        logic [31:0] w_data;
        logic [3:0] w_strb;
        logic bvalid;
        logic [1:0] bresp;
        logic rvalid;
        logic [31:0] rdata;
        logic [1:0] rresp;
        logic [coc_pkg::CTRL_W-1:0] ctrl;
        logic [coc_pkg::MUX_W-1:0] mux;
        logic [coc_pkg::INT_W-1:0] istat;
        logic [coc_pkg::INT_W-1:0] imask;
        logic sync_q;
        logic rst_en;
        logic rst_cause;
        logic rst_req;
    } coc_state_t;

    coc_state_t st_reg;
    coc_state_t st_next;
    logic filt;
    logic en;
    logic do_wr;
    logic keep_en;
    logic keep_cause;
    logic [31:0] wr_val;
    logic [coc_pkg::INT_W-1:0] ev;

    // byte-lane merge of a write into the old value
    function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] d,
                                          input logic [3:0] s);
        logic [31:0] r;
        r = old;
        for (int i = 0; i < 4; i++) begin
            if (s[i]) begin
                r[8*i +: 8] = d[8*i +: 8];
            end
        end
        return r;
    endfunction

    // ************************************************************
    // synchroniser of the comparator decision
    // ************************************************************
    coc_sync #(
        .STAGES(coc_pkg::SYNC_STAGES)
    ) u_sync (
        .aclk(aclk),
        .aresetn(aresetn),
        .async_in(comp_decision),
        .sync_out(filt)
    );

    assign en = st_reg.ctrl[coc_pkg::EN_BIT];

    // ************************************************************
    // next state: bus slave, registers, events, reset source
    // ************************************************************
    always_comb begin
        st_next = st_reg;
        wr_val = 32'h0000_0000;
        ev = '0;
        keep_en = st_reg.rst_en;
        keep_cause = st_reg.rst_cause;
        // write address and data are taken in either order
        if (awvalid && awready) begin
            st_next.aw_got = 1'b1;
            st_next.aw_addr = awaddr[coc_pkg::ADDR_W-1:0];
        end
        if (wvalid && wready) begin
            st_next.w_got = 1'b1;
            st_next.w_data = wdata;
            st_next.w_strb = wstrb;
        end
        if (st_reg.bvalid && bready) begin
            st_next.bvalid = 1'b0;
        end
        // register write once both halves are held
        if (do_wr) begin
            st_next.aw_got = 1'b0;
            st_next.w_got = 1'b0;
            st_next.bvalid = 1'b1;
            st_next.bresp = coc_pkg::RESP_OKAY;
            case (st_reg.aw_addr)
                coc_pkg::OFS_CTRL: begin
                    wr_val = merge(32'(st_reg.ctrl), st_reg.w_data, st_reg.w_strb);
                    st_next.ctrl = wr_val[coc_pkg::CTRL_W-1:0];
                end
                coc_pkg::OFS_MUX: begin
                    wr_val = merge(32'(st_reg.mux), st_reg.w_data, st_reg.w_strb);
                    st_next.mux = wr_val[coc_pkg::MUX_W-1:0];
                end
                coc_pkg::OFS_STATUS: begin
                    st_next.bresp = coc_pkg::RESP_OKAY;
                end
                coc_pkg::OFS_INT_STAT: begin
                    // write one to clear, only in enabled lanes
                    if (st_reg.w_strb[0]) begin
                        st_next.istat = st_reg.istat & ~st_reg.w_data[coc_pkg::INT_W-1:0];
                    end
                end
                coc_pkg::OFS_INT_MASK: begin
                    wr_val = merge(32'(st_reg.imask), st_reg.w_data, st_reg.w_strb);
                    st_next.imask = wr_val[coc_pkg::INT_W-1:0];
                end
                coc_pkg::OFS_RST_SRC: begin
                    if (st_reg.w_strb[0]) begin
                        st_next.rst_en = st_reg.w_data[coc_pkg::RST_CMP_BIT];
                        st_next.rst_cause = 1'b0;
                    end
                end
                default: begin
                    st_next.bresp = coc_pkg::RESP_SLVERR;
                end
            endcase
        end
        // read path: one outstanding read, answer from a register
        if (st_reg.rvalid && rready) begin
            st_next.rvalid = 1'b0;
        end
        if (arvalid && arready) begin
            st_next.rvalid = 1'b1;
            st_next.rresp = coc_pkg::RESP_OKAY;
            case (araddr[coc_pkg::ADDR_W-1:0])
                coc_pkg::OFS_CTRL: st_next.rdata = 32'(st_reg.ctrl);
                coc_pkg::OFS_MUX: st_next.rdata = 32'(st_reg.mux);
                coc_pkg::OFS_STATUS: begin
                    st_next.rdata = (32'(st_reg.sync_q) << coc_pkg::ST_SYNC_BIT)
                                  | (32'(en) << coc_pkg::ST_EN_BIT);
                end
                coc_pkg::OFS_INT_STAT: st_next.rdata = 32'(st_reg.istat);
                coc_pkg::OFS_INT_MASK: st_next.rdata = 32'(st_reg.imask);
                coc_pkg::OFS_RST_SRC: begin
                    st_next.rdata = 32'(st_reg.rst_cause) << coc_pkg::RST_CMP_BIT;
                end
                default: begin
                    st_next.rdata = 32'h0000_0000;
                    st_next.rresp = coc_pkg::RESP_SLVERR;
                end
            endcase
        end
        // latched result, forced low while disabled
        st_next.sync_q = st_next.ctrl[coc_pkg::EN_BIT] & filt;
        // edges of the latched result; a set beats a same-cycle clear
        ev[coc_pkg::INT_RISE_BIT] = st_next.sync_q & ~st_reg.sync_q;
        ev[coc_pkg::INT_FALL_BIT] = ~st_next.sync_q & st_reg.sync_q;
        st_next.istat = st_next.istat | ev;
        // reset request while non-inverting input sits below inverting
        st_next.rst_req = st_reg.rst_en & en & ~st_reg.sync_q;
        if (st_reg.rst_req) begin
            st_next.rst_cause = 1'b1;
        end
        // bus reset spares the reset source flags so the cause survives
        if (!aresetn) begin
            st_next = '0;
            st_next.ctrl = coc_pkg::CTRL_RST;
            st_next.mux = coc_pkg::MUX_RST;
            st_next.imask = coc_pkg::INT_MASK_RST;
            st_next.rst_en = keep_en;
            st_next.rst_cause = keep_cause | st_reg.rst_req;
        end
        if (!por_n) begin
            st_next.rst_en = 1'b0;
            st_next.rst_cause = 1'b0;
        end
    end

    always_ff @(posedge aclk) begin
        st_reg <= st_next;
    end

    // ************************************************************
    // bus handshakes
    // ************************************************************
    // a pending response blocks new writes so only one is in flight
    assign do_wr = st_reg.aw_got && st_reg.w_got && !st_reg.bvalid;
    assign awready = !st_reg.aw_got && !st_reg.bvalid;
    assign wready = !st_reg.w_got && !st_reg.bvalid;
    assign arready = !st_reg.rvalid;
    assign bvalid = st_reg.bvalid;
    assign bresp = st_reg.bresp;
    assign rvalid = st_reg.rvalid;
    assign rdata = st_reg.rdata;
    assign rresp = st_reg.rresp;

    // ************************************************************
    // analog controls and outputs
    // ************************************************************
    // supply follows the enable; no supply while disabled
    assign comp_power_en = en;
    assign comp_response_mode = st_reg.ctrl[coc_pkg::RESP_LSB +: 2];
    assign comp_hyst_pos = st_reg.ctrl[coc_pkg::HYSP_LSB +: 2];
    assign comp_hyst_neg = st_reg.ctrl[coc_pkg::HYSN_LSB +: 2];
    assign noninverting_input = st_reg.mux[coc_pkg::POS_LSB +: coc_pkg::SEL_W];
    assign inverting_input = st_reg.mux[coc_pkg::NEG_LSB +: coc_pkg::SEL_W];

    // raw path has no flop on it so it works with aclk stopped
    assign comparator_raw_out = comp_decision & en;
    assign comparator_sync_out = st_reg.sync_q;

    // pin drive: open-drain only ever pulls low, enable low means driving
    always_comb begin
        sync_pin_out = 1'b0;
        sync_pin_oe_n = 1'b1;
        raw_pin_out = 1'b0;
        raw_pin_oe_n = 1'b1;
        if (st_reg.ctrl[coc_pkg::SYNC_PIN_BIT]) begin
            if (st_reg.ctrl[coc_pkg::SYNC_OD_BIT]) begin
                sync_pin_oe_n = comparator_sync_out;
            end else begin
                sync_pin_out = comparator_sync_out;
                sync_pin_oe_n = 1'b0;
            end
        end
        if (st_reg.ctrl[coc_pkg::RAW_PIN_BIT]) begin
            if (st_reg.ctrl[coc_pkg::RAW_OD_BIT]) begin
                raw_pin_oe_n = comparator_raw_out;
            end else begin
                raw_pin_out = comparator_raw_out;
                raw_pin_oe_n = 1'b0;
            end
        end
    end

    assign irq = |(st_reg.istat & st_reg.imask);
    assign comp_reset_req = st_reg.rst_req;

    // ************************************************************
    // assertions
    // ************************************************************
    default clocking cb @(posedge aclk);
    endclocking
    default disable iff (!aresetn);

    a_raw_low_off: assert property (!en |-> !comparator_raw_out)
        else $error("raw output high while disabled");
    a_sync_low_off: assert property (!en |-> !comparator_sync_out && !sync_pin_out)
        else $error("latched output high while disabled");
    a_power_off: assert property ($fell(en) |-> !comp_power_en)
        else $error("comparator supply kept after disable");
    a_sync_latency: assert property (
        (en && comp_decision)[*5] ##1 en |-> comparator_sync_out)
        else $error("latched output late after steady input");
    a_pin_pushpull: assert property (
        sync_pin_oe_n == 1'b0 |-> sync_pin_out == comparator_sync_out)
        else $error("push-pull pin differs from output");
    a_pin_opendrain: assert property (
        st_reg.ctrl[coc_pkg::RAW_PIN_BIT] && st_reg.ctrl[coc_pkg::RAW_OD_BIT]
        |-> !raw_pin_out && raw_pin_oe_n == comparator_raw_out)
        else $error("open-drain pin drives high");
    a_rise_event: assert property (
        $rose(comparator_sync_out) |-> st_reg.istat[coc_pkg::INT_RISE_BIT])
        else $error("rising edge did not set status");
    a_fall_event: assert property (
        $fell(comparator_sync_out) |-> st_reg.istat[coc_pkg::INT_FALL_BIT])
        else $error("falling edge did not set status");
    a_irq_level: assert property (
        st_reg.istat[coc_pkg::INT_FALL_BIT] && st_reg.imask[coc_pkg::INT_FALL_BIT]
        |-> irq)
        else $error("unmasked status without interrupt");
    a_reset_cause: assert property (
        comp_reset_req && por_n |=> st_reg.rst_cause)
        else $error("reset cause not recorded");
    a_reset_when: assert property (
        st_reg.rst_en && en && !comparator_sync_out && por_n |=> comp_reset_req)
        else $error("reset not requested on low decision");
    a_reset_armed: assert property (comp_reset_req |-> $past(st_reg.rst_en))
        else $error("reset requested while not armed");
    a_bresp_hold: assert property (bvalid && !bready |=> bvalid && $stable(bresp))
        else $error("write response dropped early");

    c_rise: cover property ($rose(comparator_sync_out));
    c_reset: cover property ($rose(comp_reset_req));
    c_write: cover property (bvalid && bready);
    c_irq: cover property ($rose(irq));
endmodule

`default_nettype wire

//--- coc_ext_model.sv
`timescale 1ns/1ps
`default_nettype none

// ****************************************************************
// external circuitry at the comparator inputs and output pins
// ****************************************************************
module coc_ext_model #(
    parameter int SETTLE_NS = 3
) (
    // level asked for by the bench and the analog decision it causes
    input wire logic level_cmd,
    output logic comp_decision,
    // pin drivers of the block and the levels seen on the board
    input wire logic sync_pin_out,
    input wire logic sync_pin_oe_n,
    input wire logic raw_pin_out,
    input wire logic raw_pin_oe_n,
    output logic sync_pin_level,
    output logic raw_pin_level
);
    // the analog stage settles a little after its inputs move
    initial comp_decision = 1'h0;
    always @(level_cmd) begin
        comp_decision <= #(SETTLE_NS) level_cmd;
    end

    // a released pin floats up to the board pull-up, so open-drain shows high
    assign sync_pin_level = sync_pin_oe_n ? 1'h1 : sync_pin_out;
    assign raw_pin_level = raw_pin_oe_n ? 1'h1 : raw_pin_out;
endmodule

`default_nettype wire

//--- coc_pkg.sv
package coc_pkg;

// ****************************************************************
// Notes on behaviour
// - two outputs go to the pins, one synchronous to aclk and one raw, passed without a clock.
// - the raw output keeps following the comparator decision even while aclk is stopped.
// - while the comparator is disabled every output routed to a pin is driven low.
// - clearing the enable also removes the supply control of the analog comparator.
// - software can read the comparator result and it feeds the interrupt logic, pins or not.
// - the comparator output is offered to the reset logic as a reset source.
// - a routed output drives its pin open-drain or push-pull as its own setting says.
// - software sets response time, hysteresis and the input multiplexer selection.
// - bit 5 of the reset source register arms the reset; it reads one only after such a reset (set one cycle after the request rises, reset or not).
// - when armed and the comparator enabled, reset is requested while the non-inverting input is below the inverting one.
// ****************************************************************

    // ************************************************************
    // register map
    // ************************************************************
    localparam int ADDR_W = 8;
    localparam logic [7:0] OFS_CTRL = 8'h00;
    localparam logic [7:0] OFS_MUX = 8'h04;
    localparam logic [7:0] OFS_STATUS = 8'h08;
    localparam logic [7:0] OFS_INT_STAT = 8'h0C;
    localparam logic [7:0] OFS_INT_MASK = 8'h10;
    localparam logic [7:0] OFS_RST_SRC = 8'h14;

    // control register fields
    localparam int CTRL_W = 12;
    localparam int EN_BIT = 0;
    localparam int RESP_LSB = 1;
    localparam int HYSP_LSB = 4;
    localparam int HYSN_LSB = 6;
    localparam int SYNC_PIN_BIT = 8;
    localparam int RAW_PIN_BIT = 9;
    localparam int SYNC_OD_BIT = 10;
    localparam int RAW_OD_BIT = 11;
    localparam logic [11:0] CTRL_RST = 12'h000;

    // multiplexer register fields
    localparam int MUX_W = 8;
    localparam int SEL_W = 4;
    localparam int POS_LSB = 0;
    localparam int NEG_LSB = 4;
    localparam logic [7:0] MUX_RST = 8'h00;

    // status, interrupt and reset source fields
    localparam int ST_SYNC_BIT = 0;
    localparam int ST_EN_BIT = 1;
    localparam int INT_W = 2;
    localparam int INT_RISE_BIT = 0;
    localparam int INT_FALL_BIT = 1;
    localparam logic [1:0] INT_MASK_RST = 2'h0;
    localparam int RST_CMP_BIT = 5;

    // bus answers and synchroniser depth
    localparam logic [1:0] RESP_OKAY = 2'h0;
    localparam logic [1:0] RESP_SLVERR = 2'h2;
    localparam int SYNC_STAGES = 3;

endpackage

//--- coc_sync.sv
`timescale 1ns/1ps
`default_nettype none

// three-stage level synchroniser with an agreement filter
module coc_sync #(
    parameter int STAGES = 3
) (
    // clock and reset
    input wire logic aclk,
    input wire logic aresetn,
    // level from another domain and its filtered copy
    input wire logic async_in,
    output logic sync_out
);
    typedef struct packed {
        logic [STAGES-1:0] chain;
        logic level;
    } coc_sync_t;

    coc_sync_t st_reg;
    coc_sync_t st_next;

    // stage 0 feeds only stage 1; the filter looks at the last two stages
    always_comb begin
        st_next = st_reg;
        st_next.chain = {st_reg.chain[STAGES-2:0], async_in};
        if (st_reg.chain[STAGES-1] == st_reg.chain[STAGES-2]) begin
            st_next.level = st_reg.chain[STAGES-1];
        end
        if (!aresetn) begin
            st_next = '0;
        end
    end

    always_ff @(posedge aclk) begin
        st_reg <= st_next;
    end

    assign sync_out = st_reg.level;
endmodule

`default_nettype wire

//--- comparator_output_control_tb.sv
`timescale 1ns/1ps
`default_nettype none

module comparator_output_control_tb;
    // ****************************************************************
    // clock, reset and bus signals
    // ****************************************************************
    logic aclk = 1'h0;
    logic clk_run = 1'h1;
    logic aresetn = 1'h0;
    logic por_n = 1'h0;
    logic awvalid = 1'h0, wvalid = 1'h0, bready = 1'h0, arvalid = 1'h0, rready = 1'h0;
    logic [31:0] awaddr = 32'h0, wdata = 32'h0, araddr = 32'h0;
    logic [3:0] wstrb = 4'hF;
    logic [2:0] awprot = 3'h0, arprot = 3'h0;
    logic awready, wready, bvalid, arready, rvalid;
    logic [1:0] bresp, rresp;
    logic [31:0] rdata;
    logic comp_decision, comp_power_en, level_cmd = 1'h0;
    logic [1:0] comp_response_mode, comp_hyst_pos, comp_hyst_neg;
    logic [3:0] noninverting_input, inverting_input;
    logic comparator_sync_out, comparator_raw_out, sync_pin_out, sync_pin_oe_n;
    logic raw_pin_out, raw_pin_oe_n, irq, comp_reset_req, sync_pin_level, raw_pin_level;
    int mismatches = 0;
    int cmp_count = 0;

    // stoppable clock, so the raw path can be seen working without it
    always #10 begin
        if (clk_run) aclk = ~aclk;
    end

    coc_comparator_ctrl dut_u (
        .aclk, .aresetn, .por_n, .awvalid, .awready, .awaddr, .awprot,
        .wvalid, .wready, .wdata, .wstrb, .bvalid, .bready, .bresp,
        .arvalid, .arready, .araddr, .arprot, .rvalid, .rready, .rdata, .rresp,
        .comp_decision, .comp_power_en, .comp_response_mode, .comp_hyst_pos,
        .comp_hyst_neg, .noninverting_input, .inverting_input,
        .comparator_sync_out, .comparator_raw_out, .sync_pin_out, .sync_pin_oe_n,
        .raw_pin_out, .raw_pin_oe_n, .irq, .comp_reset_req
    );

    coc_ext_model ext_u (
        .level_cmd, .comp_decision, .sync_pin_out, .sync_pin_oe_n,
        .raw_pin_out, .raw_pin_oe_n, .sync_pin_level, .raw_pin_level
    );

    // ****************************************************************
    // compare, bus and wait tasks
    // ****************************************************************
    task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
        cmp_count++;
        if (seen !== exp) begin
            mismatches++;
            $display("[ERR] %s expected %h seen %h", what, exp, seen);
        end
    endtask

    // both halves offered together, each dropped once taken; waits for the answer
    task automatic wr(input logic [7:0] a, input logic [31:0] d, output logic [1:0] r);
        @(posedge aclk);
        awaddr <= {24'h0, a};
        wdata <= d;
        awvalid <= 1'h1;
        wvalid <= 1'h1;
        bready <= 1'h1;
        do begin
            @(posedge aclk);
            if (awvalid && awready) awvalid <= 1'h0;
            if (wvalid && wready) wvalid <= 1'h0;
        end while (bvalid !== 1'h1);
        r = bresp;
        bready <= 1'h0;
        #1;
    endtask

    task automatic rd(input logic [7:0] a, output logic [31:0] d, output logic [1:0] r);
        @(posedge aclk);
        araddr <= {24'h0, a};
        arvalid <= 1'h1;
        rready <= 1'h1;
        do begin
            @(posedge aclk);
            if (arvalid && arready) arvalid <= 1'h0;
        end while (rvalid !== 1'h1);
        d = rdata;
        r = rresp;
        rready <= 1'h0;
        #1;
    endtask

    task automatic wr_exp(input logic [7:0] a, input logic [31:0] d, input logic [1:0] er);
        logic [1:0] r;
        wr(a, d, r);
        check("bresp", 32'(r), 32'(er));
    endtask

    task automatic rd_exp(input logic [7:0] a, input logic [31:0] exp, input logic [1:0] er);
        logic [31:0] d;
        logic [1:0] r;
        rd(a, d, r);
        check("rdata", d, exp);
        check("rresp", 32'(r), 32'(er));
    endtask

    // waits whole cycles, then lets that edge's updates land
    task automatic cyc(input int n);
        repeat (n) @(posedge aclk);
        #1;
    endtask

    task automatic conclude();
        $display("comparisons %0d mismatches %0d", cmp_count, mismatches);
        if (mismatches == 0 && cmp_count > 0) begin
            $display("Simulation passed");
        end else begin
            $display("Simulation failed");
        end
        $finish;
    endtask

    // ****************************************************************
    // scenarios
    // ****************************************************************
    initial begin
        repeat (2) @(posedge aclk);
        aresetn <= 1'h1;
        por_n <= 1'h1;
        #1;
        // reset state, unmapped and read-only places
        check("power", 32'(comp_power_en), 32'h0);
        check("sync_oe_n", 32'(sync_pin_oe_n), 32'h1);
        rd_exp(coc_pkg::OFS_CTRL, 32'h0, coc_pkg::RESP_OKAY);
        rd_exp(coc_pkg::OFS_RST_SRC, 32'h0, coc_pkg::RESP_OKAY);
        rd_exp(8'h40, 32'h0, coc_pkg::RESP_SLVERR);
        wr_exp(8'h40, 32'hFFFFFFFF, coc_pkg::RESP_SLVERR);
        wr_exp(coc_pkg::OFS_STATUS, 32'h3, coc_pkg::RESP_OKAY);
        rd_exp(coc_pkg::OFS_STATUS, 32'h0, coc_pkg::RESP_OKAY);
        // input selection, response time and hysteresis, both pins routed
        wr_exp(coc_pkg::OFS_MUX, 32'hA5, coc_pkg::RESP_OKAY);
        check("noninv", 32'(noninverting_input), 32'h5);
        check("inv", 32'(inverting_input), 32'hA);
        wr_exp(coc_pkg::OFS_CTRL, 32'h367, coc_pkg::RESP_OKAY);
        check("resp", 32'(comp_response_mode), 32'h3);
        check("hysp", 32'(comp_hyst_pos), 32'h2);
        check("hysn", 32'(comp_hyst_neg), 32'h1);
        check("power", 32'(comp_power_en), 32'h1);
        // rising result: raw at once, latched later, polled and interrupting
        wr_exp(coc_pkg::OFS_INT_MASK, 32'h1, coc_pkg::RESP_OKAY);
        level_cmd = 1'h1;
        #5;
        check("raw", 32'(comparator_raw_out), 32'h1);
        check("sync early", 32'(comparator_sync_out), 32'h0);
        cyc(7);
        check("sync", 32'(comparator_sync_out), 32'h1);
        check("irq", 32'(irq), 32'h1);
        rd_exp(coc_pkg::OFS_STATUS, 32'h3, coc_pkg::RESP_OKAY);
        rd_exp(coc_pkg::OFS_INT_STAT, 32'h1, coc_pkg::RESP_OKAY);
        wr_exp(coc_pkg::OFS_INT_STAT, 32'h1, coc_pkg::RESP_OKAY);
        check("irq clr", 32'(irq), 32'h0);
        // push-pull then open-drain drive of both pins
        for (int od = 0; od < 2; od++) begin
            wr_exp(coc_pkg::OFS_CTRL, 32'h367 | (od != 0 ? 32'hC00 : 32'h0), 2'h0);
            check("sync pin", 32'(sync_pin_out), 32'(od == 0));
            check("sync oe_n", 32'(sync_pin_oe_n), 32'(od != 0));
            check("raw pin", 32'(raw_pin_out), 32'(od == 0));
            check("raw oe_n", 32'(raw_pin_oe_n), 32'(od != 0));
            check("pin level", 32'(raw_pin_level & sync_pin_level), 32'h1);
        end
        // raw output keeps following with the clock halted
        clk_run = 1'h0;
        #30;
        level_cmd = 1'h0;
        #10;
        check("raw stopped", 32'(comparator_raw_out), 32'h0);
        level_cmd = 1'h1;
        #10;
        check("raw stopped", 32'(comparator_raw_out), 32'h1);
        clk_run = 1'h1;
        // disabled while routed open-drain with the input high
        wr_exp(coc_pkg::OFS_CTRL, 32'hF00, coc_pkg::RESP_OKAY);
        cyc(2);
        check("power off", 32'(comp_power_en), 32'h0);
        check("raw off", 32'(comparator_raw_out), 32'h0);
        check("sync off", 32'(comparator_sync_out), 32'h0);
        check("pins low", 32'(raw_pin_level | sync_pin_level), 32'h0);
        rd_exp(coc_pkg::OFS_STATUS, 32'h0, coc_pkg::RESP_OKAY);
        // reset source: no request until armed, then while input is below
        wr_exp(coc_pkg::OFS_CTRL, 32'h367, coc_pkg::RESP_OKAY);
        cyc(7);
        // enabling with the input high raised the latched result; clear both events
        wr_exp(coc_pkg::OFS_INT_STAT, 32'h3, coc_pkg::RESP_OKAY);
        level_cmd = 1'h0;
        cyc(7);
        check("irq masked", 32'(irq), 32'h0);
        rd_exp(coc_pkg::OFS_INT_STAT, 32'h2, coc_pkg::RESP_OKAY);
        check("req unarmed", 32'(comp_reset_req), 32'h0);
        wr_exp(coc_pkg::OFS_RST_SRC, 32'h20, coc_pkg::RESP_OKAY);
        cyc(3);
        check("req armed", 32'(comp_reset_req), 32'h1);
        rd_exp(coc_pkg::OFS_RST_SRC, 32'h20, coc_pkg::RESP_OKAY);
        wr_exp(coc_pkg::OFS_RST_SRC, 32'h0, coc_pkg::RESP_OKAY);
        cyc(3);
        check("req disarmed", 32'(comp_reset_req), 32'h0);
        // bus reset keeps the recorded cause, power-on reset clears it
        @(posedge aclk);
        aresetn <= 1'h0;
        repeat (2) @(posedge aclk);
        aresetn <= 1'h1;
        #1;
        check("power rst", 32'(comp_power_en), 32'h0);
        rd_exp(coc_pkg::OFS_RST_SRC, 32'h20, coc_pkg::RESP_OKAY);
        @(posedge aclk);
        por_n <= 1'h0;
        @(posedge aclk);
        por_n <= 1'h1;
        #1;
        rd_exp(coc_pkg::OFS_RST_SRC, 32'h0, coc_pkg::RESP_OKAY);
        conclude();
    end

    // hang guard, well beyond the 121 or so cycles the scenarios need
    initial begin
        repeat (3000) @(posedge aclk);
        mismatches++;
        conclude();
    end
endmodule

`default_nettype wire
